// ==== hdl/aods_cfg.svh ====
`ifndef AODS_CFG_SVH
`define AODS_CFG_SVH
// host byte register addresses
`define A_SAMPLE_RATE 8'h05
`define A_INT_EN 8'h07
`define A_INT_STAT 8'h09
`define A_APPLY 8'h13
`define A_HDR_FIRST 8'h42
`define A_HDR_INFO 8'h43
`define A_SRC 8'h4c
`define A_ALGO 8'h4d
`define A_DO_CMD 8'h5e
`define A_DO_CAT 8'h5f
`define A_DO_FMT 8'h60
`define A_DO_CS 8'h61
`define A_PP_SEL 8'h62
`define A_PP_MODE 8'h64
`define A_LFE 8'h68
`define A_COMP 8'h69
`define A_RNG_HI 8'h6a
`define A_RNG_LO 8'h6b
`define A_CRC 8'h6c
`define A_MCK 8'h6d
`define A_DUAL 8'h6e
`define A_DMX 8'h6f
`define A_FDS 8'h70
`define A_PCM_ASG 8'ha8
`define A_PCM_MC 8'ha9
`define A_AUX_MIX 8'hae
// storage layout
`define NREG 23
`define NOREG 5'h1f
`define RESET_VAL 8'h00
// register values
`define APPLY_GO 8'h01
`define CMD_LR 8'h02
`define CMD_AUX 8'h82
`define CMD_COMP 8'h03
`define FMT_STD 8'h21
`define FMT_BIT_24 0
`define FMT_BIT_256 5
`define CS_STD 8'h02
`define CS_BIT_COMP 0
`define CS_BIT_COPY 1
`define CS_BIT_PRE 2
`define CS_RATE_HI 7
`define CS_RATE_LO 6
`define MIX_3D 8'h01
`define MIX_COPY 8'h02
`define MIX_MATRIX 8'h08
`define MIX_DMX20 8'h10
`define SRC_SERIAL 8'h03
`define SRC_DIGITAL 8'h05
`define CRC_MUTE 8'h00
`define MC_ON 8'h10
`define MC_FIRST 8'h01
`define FDS_BIT 0
`define INT_HDR_BIT 1
`define DMX_MULTI 8'h03
// detected stream type codes
`define ST_NONE 3'h0
`define ST_MPEG12 3'h1
`define ST_SURR_A 3'h2
`define ST_SURR_B 3'h3
`define ST_PCM 3'h4
`define ST_MPEG3 3'h5
// soft mute length
`define MUTE_NS 10000
`define CLK_NS 10
`define MUTE_CYC ((`MUTE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== hdl/aods_pkg.sv ====
package aods_pkg;
  typedef enum logic [3:0] {
    ALG_SURR_A, ALG_MPEG1, ALG_MPEG2, ALG_PCM, ALG_PINK, ALG_SURR_B,
    ALG_BEEP, ALG_LOSSLESS, ALG_MPEG3, ALG_NONE
  } aods_algo_t;
  typedef enum logic [2:0] {MIX_NONE, MIX_COPY, MIX_MATRIX, MIX_DMX20, MIX_3D} aods_mix_t;
  typedef enum logic [1:0] {DO_OFF, DO_LR, DO_AUX, DO_COMP} aods_do_mode_t;
  typedef enum logic {MS_RUN, MS_MUTE} aods_mute_t;
endpackage : aods_pkg

// ==== hdl/aods_top.sv ====
`timescale 1ns/100ps
`include "aods_cfg.svh"

module aods_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wptr, rptr, next_wptr, next_rptr;
  logic push, pop;
  assign wr_ready = (wptr - rptr) != (AW+1)'(D);
  assign rd_valid = wptr != rptr;
  assign rd_data = mem[rptr[AW-1:0]];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  always_comb begin
    next_wptr = push ? wptr + (AW+1)'(1) : wptr;
    next_rptr = pop ? rptr + (AW+1)'(1) : rptr;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      if (push) begin
        mem[wptr[AW-1:0]] <= wr_data;
      end
    end
  end
endmodule : aods_fifo

// Overview of operation
// R01: command 2 sends main pair, 0x82 aux
// R02: command 3 sends framed compressed bitstream
// R03: uncompressed output carries only main or aux
// R04: output settings take effect on play write
// R05: format 0x21: 256fs, 24-bit, round 16
// R06: status 0x02: pcm, copy ok, 44.1k
// R07: compressed output passes only three stream types
// R08: aux mix: copy, matrix downmix, 2/0 downmix
// R09: 3d on aux disables it elsewhere
// R10: algorithm register picks the decoder
// R11: host sets source 3 serial, 5 digital
// R12: autodetect only on compressed digital input
// R13: new type: soft mute and decoder reset
// R14: no detection on serial, none for pcm
// R15: register 0x43 reports decoded stream type
// R16: header event can raise an interrupt
// R17: decoder settings apply live, no restart
// R18: karaoke mode from vocals and layout
// R19: elementary pcm accepts only 16-bit stereo
// R20: forced downsampling only for packetised pcm; code does not check for pcm
// R21: crc value 0 mutes bad blocks
// R22: 16 enables multichannel, 1 first-gen
// R23: reading 0x42 clears header event bit
// R24: all settings 8-bit, read/write, held
module aods_top
  import aods_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_rdata,
  input wire logic hdr_event,
  input wire logic [2:0] hdr_type,
  input wire logic [7:0] hdr_byte,
  input wire logic crc_error,
  input wire logic [1:0] vocal_count,
  input wire logic pes_input,
  input wire logic pcm_16bit_stereo,
  input wire logic pcm_valid,
  output logic pcm_ready,
  input wire logic [23:0] lr_left,
  input wire logic [23:0] lr_right,
  input wire logic [23:0] aux_left,
  input wire logic [23:0] aux_right,
  input wire logic comp_valid,
  output logic comp_ready,
  input wire logic [31:0] comp_data,
  output logic do_valid,
  input wire logic do_ready,
  output logic [31:0] do_data,
  output logic do_compressed,
  output logic [7:0] do_category,
  output logic cs_compressed,
  output logic cs_copy_ok,
  output logic cs_preemph,
  output logic [1:0] cs_rate_code,
  output logic conv_clk_256fs,
  output logic conv_24bit,
  output logic do_round16,
  output aods_mix_t aux_mix,
  output logic main_3d_disable,
  output aods_algo_t algo,
  output logic source_digital,
  output logic soft_mute,
  output logic decoder_reset,
  output logic block_mute,
  output logic mc_decode_en,
  output logic denorm_en,
  output logic mpeg1_compat,
  output logic [1:0] karaoke_mode,
  output logic force_downsample_en,
  output logic pcm_drop,
  output logic irq
);
  function automatic logic [4:0] addr_idx(input logic [7:0] a);
    case (a)
      `A_SAMPLE_RATE: addr_idx = 5'h00;
      `A_INT_EN: addr_idx = 5'h01;
      `A_APPLY: addr_idx = 5'h02;
      `A_SRC: addr_idx = 5'h03;
      `A_ALGO: addr_idx = 5'h04;
      `A_DO_CMD: addr_idx = 5'h05;
      `A_DO_CAT: addr_idx = 5'h06;
      `A_DO_FMT: addr_idx = 5'h07;
      `A_DO_CS: addr_idx = 5'h08;
      `A_PP_SEL: addr_idx = 5'h09;
      `A_PP_MODE: addr_idx = 5'h0a;
      `A_LFE: addr_idx = 5'h0b;
      `A_COMP: addr_idx = 5'h0c;
      `A_RNG_HI: addr_idx = 5'h0d;
      `A_RNG_LO: addr_idx = 5'h0e;
      `A_CRC: addr_idx = 5'h0f;
      `A_MCK: addr_idx = 5'h10;
      `A_DUAL: addr_idx = 5'h11;
      `A_DMX: addr_idx = 5'h12;
      `A_FDS: addr_idx = 5'h13;
      `A_PCM_ASG: addr_idx = 5'h14;
      `A_PCM_MC: addr_idx = 5'h15;
      `A_AUX_MIX: addr_idx = 5'h16;
      default: addr_idx = `NOREG;
    endcase
  endfunction : addr_idx

  // saturating round of a 24-bit sample to 16 bits
  function automatic logic [15:0] to16(input logic [23:0] s, input logic rnd);
    logic [24:0] sum;
    sum = {s[23], s} + 25'h80;
    if (!rnd) begin
      to16 = s[23:8];
    end else if (sum[24] != sum[23]) begin
      to16 = s[23] ? 16'h8000 : 16'h7fff;
    end else begin
      to16 = sum[23:8];
    end
  endfunction : to16

  logic [7:0] cfg [`NREG];
  logic [7:0] next_cfg [`NREG];
  logic [7:0] act_cmd, act_cat, act_fmt, act_cs;
  logic [7:0] next_act_cmd, next_act_cat, next_act_fmt, next_act_cs;
  logic hdr_flag, next_hdr_flag;
  logic [7:0] hdr_first, next_hdr_first;
  logic [2:0] cur_type, next_cur_type;
  logic [7:0] next_host_rdata;
  aods_mute_t mstate, next_mstate;
  logic [15:0] mcount, next_mcount;
  logic next_decoder_reset;
  logic [4:0] widx;
  logic apply_wr, hdr_rd, detectable, new_type;
  logic [7:0] src_reg, algo_reg, mix_reg, crc_reg, mck_reg, dmx_reg, fds_reg, inten_reg;
  aods_do_mode_t do_mode;
  logic pass_ok, fifo_wr_valid, fifo_wr_ready, rnd;
  logic [31:0] fifo_wr_data;

  assign src_reg = cfg[addr_idx(`A_SRC)];
  assign algo_reg = cfg[addr_idx(`A_ALGO)];
  assign mix_reg = cfg[addr_idx(`A_AUX_MIX)];
  assign crc_reg = cfg[addr_idx(`A_CRC)];
  assign mck_reg = cfg[addr_idx(`A_MCK)];
  assign dmx_reg = cfg[addr_idx(`A_DMX)];
  assign fds_reg = cfg[addr_idx(`A_FDS)];
  assign inten_reg = cfg[addr_idx(`A_INT_EN)];
  assign widx = addr_idx(host_addr);
  assign apply_wr = host_wr && host_addr == `A_APPLY && host_wdata == `APPLY_GO;
  assign hdr_rd = host_rd && host_addr == `A_HDR_FIRST;
  assign source_digital = src_reg == `SRC_DIGITAL; // [R11]
  // pcm type and layer 3 are never detected; serial input never detects
  assign detectable = source_digital && (hdr_type == `ST_MPEG12 || hdr_type == `ST_SURR_A
                      || hdr_type == `ST_SURR_B); // [R12] [R14]
  assign new_type = hdr_event && detectable && hdr_type != cur_type; // [R13]

  // register file, staged output settings, header event flag
  always_comb begin
    for (int i = 0; i < `NREG; i++) begin
      next_cfg[i] = cfg[i];
    end
    next_act_cmd = act_cmd;
    next_act_cat = act_cat;
    next_act_fmt = act_fmt;
    next_act_cs = act_cs;
    if (host_wr && widx != `NOREG) begin
      next_cfg[widx] = host_wdata; // [R24] [R17]
    end
    if (apply_wr) begin
      next_act_cmd = cfg[addr_idx(`A_DO_CMD)]; // [R04]
      next_act_cat = cfg[addr_idx(`A_DO_CAT)];
      next_act_fmt = cfg[addr_idx(`A_DO_FMT)];
      next_act_cs = cfg[addr_idx(`A_DO_CS)];
    end
    next_hdr_flag = hdr_flag;
    if (hdr_rd) begin
      next_hdr_flag = 1'b0; // [R23]
    end
    if (hdr_event) begin
      next_hdr_flag = 1'b1; // set wins over read clear [R16]
    end
    next_hdr_first = hdr_event ? hdr_byte : hdr_first;
    next_host_rdata = 8'h00;
    if (host_rd) begin
      if (widx != `NOREG) begin
        next_host_rdata = cfg[widx];
      end else if (host_addr == `A_HDR_INFO) begin
        next_host_rdata = source_digital ? {5'h00, cur_type} : 8'h00; // [R15]
      end else if (host_addr == `A_HDR_FIRST) begin
        next_host_rdata = hdr_first;
      end else if (host_addr == `A_INT_STAT) begin
        next_host_rdata = 8'(hdr_flag) << `INT_HDR_BIT;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `NREG; i++) begin
        cfg[i] <= `RESET_VAL;
      end
      act_cmd <= `RESET_VAL;
      act_cat <= `RESET_VAL;
      act_fmt <= `RESET_VAL;
      act_cs <= `RESET_VAL;
      hdr_flag <= 1'b0;
      hdr_first <= 8'h00;
      host_rdata <= 8'h00;
    end else if (ce) begin
      cfg <= next_cfg;
      act_cmd <= next_act_cmd;
      act_cat <= next_act_cat;
      act_fmt <= next_act_fmt;
      act_cs <= next_act_cs;
      hdr_flag <= next_hdr_flag;
      hdr_first <= next_hdr_first;
      host_rdata <= next_host_rdata;
    end
  end

  // stream type tracking and soft mute after a change
  always_comb begin
    next_cur_type = cur_type;
    next_mstate = mstate;
    next_mcount = mcount;
    next_decoder_reset = 1'b0;
    if (new_type) begin
      next_cur_type = hdr_type;
      next_mstate = MS_MUTE; // [R13]
      next_mcount = 16'(`MUTE_CYC - 1);
      next_decoder_reset = 1'b1;
    end else begin
      unique case (mstate)
        MS_RUN: next_mcount = 16'h0000;
        MS_MUTE: begin
          if (mcount == 16'h0000) begin
            next_mstate = MS_RUN;
          end else begin
            next_mcount = mcount - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cur_type <= `ST_NONE;
      mstate <= MS_RUN;
      mcount <= 16'h0000;
      decoder_reset <= 1'b0;
    end else if (ce) begin
      cur_type <= next_cur_type;
      mstate <= next_mstate;
      mcount <= next_mcount;
      decoder_reset <= next_decoder_reset;
    end
  end
  assign soft_mute = mstate == MS_MUTE;
  assign irq = hdr_flag && inten_reg[`INT_HDR_BIT]; // [R16]

  // output path selection; unknown commands leave the output silent
  always_comb begin
    unique case (act_cmd)
      `CMD_LR: do_mode = DO_LR; // [R01]
      `CMD_AUX: do_mode = DO_AUX; // [R01]
      `CMD_COMP: do_mode = DO_COMP; // [R02]
      default: do_mode = DO_OFF; // [R03]
    endcase
  end
  assign pass_ok = cur_type == `ST_MPEG12 || cur_type == `ST_SURR_A || cur_type == `ST_SURR_B; // [R07]
  assign rnd = act_fmt[`FMT_BIT_24];
  // elementary pcm that is not 16-bit stereo is dropped, not decoded
  assign pcm_drop = src_reg == `SRC_SERIAL && algo == ALG_PCM && !pcm_16bit_stereo; // [R19]
  always_comb begin
    fifo_wr_valid = 1'b0;
    fifo_wr_data = {to16(lr_left, rnd), to16(lr_right, rnd)};
    pcm_ready = 1'b1;
    comp_ready = 1'b1;
    unique case (do_mode)
      DO_LR: begin
        fifo_wr_valid = pcm_valid && !pcm_drop; // [R01]
        pcm_ready = fifo_wr_ready || pcm_drop;
      end
      DO_AUX: begin
        fifo_wr_valid = pcm_valid && !pcm_drop; // [R01]
        fifo_wr_data = {to16(aux_left, rnd), to16(aux_right, rnd)};
        pcm_ready = fifo_wr_ready || pcm_drop;
      end
      DO_COMP: begin
        fifo_wr_valid = comp_valid && pass_ok; // [R02] [R07]
        fifo_wr_data = comp_data;
        comp_ready = fifo_wr_ready || !pass_ok;
      end
      DO_OFF: fifo_wr_valid = 1'b0; // [R03]
    endcase
  end

  aods_fifo #(.W(32), .D(4)) u_fifo (
    .clock(clock),
    .reset_n(reset_n),
    .ce(ce),
    .wr_valid(fifo_wr_valid),
    .wr_ready(fifo_wr_ready),
    .wr_data(fifo_wr_data),
    .rd_valid(do_valid),
    .rd_ready(do_ready),
    .rd_data(do_data)
  );

  assign do_compressed = do_mode == DO_COMP; // [R02]
  assign do_category = act_cat;
  assign conv_clk_256fs = act_fmt[`FMT_BIT_256]; // [R05]
  assign conv_24bit = act_fmt[`FMT_BIT_24]; // [R05]
  assign do_round16 = act_fmt[`FMT_BIT_24]; // [R05]
  assign cs_compressed = act_cs[`CS_BIT_COMP]; // [R06]
  assign cs_copy_ok = act_cs[`CS_BIT_COPY]; // [R06]
  assign cs_preemph = act_cs[`CS_BIT_PRE]; // [R06]
  assign cs_rate_code = act_cs[`CS_RATE_HI:`CS_RATE_LO]; // [R06]

  // decoder controls follow the registers live
  always_comb begin
    unique case (mix_reg)
      `MIX_COPY: aux_mix = MIX_COPY; // [R08]
      `MIX_MATRIX: aux_mix = MIX_MATRIX; // [R08]
      `MIX_DMX20: aux_mix = MIX_DMX20; // [R08]
      `MIX_3D: aux_mix = MIX_3D;
      default: aux_mix = MIX_NONE;
    endcase
    unique case (algo_reg)
      8'h00: algo = ALG_SURR_A; // [R10]
      8'h01: algo = ALG_MPEG1;
      8'h02: algo = ALG_MPEG2;
      8'h03: algo = ALG_PCM;
      8'h04: algo = ALG_PINK;
      8'h06: algo = ALG_SURR_B;
      8'h07: algo = ALG_BEEP;
      8'h08: algo = ALG_LOSSLESS;
      8'h09: algo = ALG_MPEG3;
      default: algo = ALG_NONE;
    endcase
    if (vocal_count == 2'h0) begin
      karaoke_mode = 2'h0; // [R18]
    end else if (dmx_reg >= `DMX_MULTI) begin
      karaoke_mode = 2'h2;
    end else begin
      karaoke_mode = 2'h1;
    end
  end
  assign main_3d_disable = aux_mix == MIX_3D; // [R09]
  assign block_mute = algo == ALG_SURR_A && crc_reg == `CRC_MUTE && crc_error; // [R21]
  assign mc_decode_en = algo == ALG_MPEG2 && mck_reg == `MC_ON; // [R22]
  assign denorm_en = mc_decode_en; // [R22]
  assign mpeg1_compat = mck_reg == `MC_FIRST; // [R22]
  assign force_downsample_en = fds_reg[`FDS_BIT] && pes_input && src_reg != `SRC_SERIAL; // [R20]

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic [7:0] cmd_reg;
  assign cmd_reg = cfg[addr_idx(`A_DO_CMD)];

  AST_APPLY_LOADS: assert property (ce && apply_wr |=> act_cmd == $past(cmd_reg)) // [R04]
    else $error("play write did not load command");
  AST_HOLD_WITHOUT_APPLY: assert property (!(ce && apply_wr) |=> $stable(act_cmd)) // [R04]
    else $error("output command changed without play");
  AST_AUX_PAIR: assert property (do_mode == DO_AUX |-> fifo_wr_data[31:16] == to16(aux_left, rnd)) // [R01]
    else $error("aux command not sending aux pair");
  AST_OFF_SILENT: assert property (do_mode == DO_OFF |-> !fifo_wr_valid) // [R03]
    else $error("output written in undefined command");
  AST_COMP_FILTER: assert property (do_mode == DO_COMP && !pass_ok |-> !fifo_wr_valid) // [R07]
    else $error("disallowed type passed through");
  AST_NEW_TYPE_MUTE: assert property (ce && new_type |=> soft_mute && decoder_reset) // [R13]
    else $error("no mute or reset on new stream type");
  AST_MUTE_HOLDS: assert property (ce && new_type ##1 ce && !new_type |=> soft_mute && !decoder_reset) // [R13]
    else $error("mute ended too early or reset too long");
  AST_HDR_CLEAR: assert property (ce && hdr_rd && !hdr_event |=> !hdr_flag) // [R23]
    else $error("header read did not clear flag");
  AST_HDR_SET: assert property (ce && hdr_event |=> hdr_flag) // [R16]
    else $error("header event lost");
  AST_SERIAL_NO_DETECT: assert property (ce && hdr_event && !source_digital |=> $stable(cur_type)) // [R14]
    else $error("type detected on serial input");
  AST_MC_ENABLE: assert property (algo == ALG_MPEG2 && mck_reg == `MC_ON |-> mc_decode_en && denorm_en) // [R22]
    else $error("multichannel decode not enabled");
  AST_CRC_MUTE: assert property (block_mute |-> crc_error && crc_reg == `CRC_MUTE) // [R21]
    else $error("block muted without crc error");

  COV_NEW_TYPE: cover property (ce && new_type);
  COV_FIFO_FULL: cover property (fifo_wr_valid && !fifo_wr_ready);
  COV_COMP_SEND: cover property (do_mode == DO_COMP && fifo_wr_valid && fifo_wr_ready);
  COV_HDR_RACE: cover property (ce && hdr_rd && hdr_event);
endmodule : aods_top

// ==== verif/aods_sink.sv ====
`timescale 1ns/100ps
module aods_sink (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic stall,
  input wire logic do_valid,
  output logic do_ready,
  input wire logic [31:0] do_data
);
  logic [31:0] rx_q[$];
  // a stalled receiver keeps ready low so the fifo backs up
  assign do_ready = !stall;
  // arrival order kept, so reordering in the fifo shows up
  always @(posedge clock) begin
    if (reset_n && do_valid && do_ready) begin
      rx_q.push_back(do_data);
    end
  end
endmodule : aods_sink

// ==== verif/aods_top_bench.sv ====
`timescale 1ns/100ps
module aods_top_bench;
  import aods_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [1:0] k; logic [3:0] e;} aods_row_t;
  logic clock, reset_n, host_wr, host_rd, hdr_event, crc_error, pes_input, pcm_16bit_stereo;
  logic pcm_valid, comp_valid, stall, pcm_ready, comp_ready, do_valid, do_ready, do_compressed;
  logic cs_compressed, cs_copy_ok, cs_preemph, conv_clk_256fs, conv_24bit, do_round16;
  logic main_3d_disable, source_digital, soft_mute, decoder_reset, block_mute, mc_decode_en;
  logic denorm_en, mpeg1_compat, force_downsample_en, pcm_drop, irq;
  logic [7:0] host_addr, host_wdata, host_rdata, hdr_byte, do_category, rv;
  logic [2:0] hdr_type;
  logic [1:0] cs_rate_code, karaoke_mode;
  logic [23:0] lr_left, lr_right, aux_left, aux_right;
  logic [31:0] comp_data, do_data;
  aods_mix_t aux_mix;
  aods_algo_t algo;
  logic ce;
  logic [1:0] vocal_count;
  logic [3:0] flg;
  int error_cnt, compares, n;
  // k: 0 algo, 1 aux mix, 2 flags {mpeg1_compat, mc&denorm, source_digital, main_3d_disable}
  aods_row_t rows[16] = '{
    '{8'h4c, 8'h03, 2'd2, 4'h0}, '{8'h4c, 8'h05, 2'd2, 4'h2},
    '{8'hae, 8'h02, 2'd1, MIX_COPY}, '{8'hae, 8'h08, 2'd1, MIX_MATRIX},
    '{8'hae, 8'h10, 2'd1, MIX_DMX20}, '{8'hae, 8'h01, 2'd1, MIX_3D}, '{8'hae, 8'h01, 2'd2, 4'h3},
    '{8'h4d, 8'h01, 2'd0, ALG_MPEG1}, '{8'h4d, 8'h03, 2'd0, ALG_PCM}, '{8'h4d, 8'h04, 2'd0, ALG_PINK},
    '{8'h4d, 8'h07, 2'd0, ALG_BEEP}, '{8'h4d, 8'h09, 2'd0, ALG_MPEG3}, '{8'h4d, 8'h0b, 2'd0, ALG_NONE},
    '{8'h4d, 8'h02, 2'd0, ALG_MPEG2}, '{8'h6d, 8'h10, 2'd2, 4'h7}, '{8'h6d, 8'h01, 2'd2, 4'hb}};

  aods_top DUT (.*);
  assign flg = {mpeg1_compat, mc_decode_en & denorm_en, source_digital, main_3d_disable};
  aods_sink SINK (.clock(clock), .reset_n(reset_n), .stall(stall), .do_valid(do_valid),
    .do_ready(do_ready), .do_data(do_data));

  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end

  task final_report;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(negedge clock);
    host_wr = 0;
  endtask : wr

  // read data stands one cycle only, so it is taken at the very next negedge
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    host_addr = a;
    host_rd = 1;
    @(negedge clock);
    host_rd = 0;
    d = host_rdata;
  endtask : rd

  task push(input logic c, input logic [31:0] w);
    int k;
    @(negedge clock);
    comp_data = w;
    lr_left = {w[31:16], 8'h00};
    lr_right = {w[15:0], 8'h00};
    aux_left = {w[15:0], 8'h00};
    aux_right = {w[31:16], 8'h00};
    if (c) comp_valid = 1;
    else pcm_valid = 1;
    k = 0;
    while (!(c ? comp_ready : pcm_ready) && k < 50) begin
      @(negedge clock);
      k++;
    end
    chk("push ready", 1, k < 50);
    @(negedge clock);
    comp_valid = 0;
    pcm_valid = 0;
  endtask : push

  // header pulse, then count decoder reset pulses over a short window
  task hdr(input logic [2:0] t);
    @(negedge clock);
    hdr_event = 1;
    hdr_type = t;
    hdr_byte = 8'ha5;
    @(negedge clock);
    hdr_event = 0;
    n = 0;
    repeat (4) begin
      if (decoder_reset === 1'b1) n++;
      @(negedge clock);
    end
  endtask : hdr

  task apply_cmd(input logic [7:0] c);
    wr(8'h5e, c);
    wr(8'h13, 8'h01);
    @(negedge clock);
    SINK.rx_q.delete();
  endtask : apply_cmd

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    final_report();
  end

  initial begin
    {reset_n, host_wr, host_rd, hdr_event, crc_error, pes_input, pcm_valid, comp_valid, stall} = '0;
    {host_addr, host_wdata, hdr_byte, hdr_type, lr_left, lr_right, aux_left, aux_right, comp_data} = '0;
    pcm_16bit_stereo = 1;
    ce = 1;
    vocal_count = 2'h0;
    repeat (8) @(negedge clock);
    reset_n = 1;
    chk("rdata idle", 0, host_rdata);
    rd(8'h5e, rv);
    chk("cmd reset", 0, rv);
    wr(8'h01, 8'h5a);
    rd(8'h01, rv);
    chk("unmapped", 0, rv);
    chk("mute reset", 0, soft_mute);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      chk("readback", rows[i].d, rv);
      case (rows[i].k)
        2'd0: chk("algo", rows[i].e, algo);
        2'd1: chk("aux_mix", rows[i].e, aux_mix);
        default: chk("flags", rows[i].e, flg);
      endcase
    end
    $display("test rows done");
    wr(8'h60, 8'h21);
    wr(8'h61, 8'h02);
    wr(8'h5f, 8'h00);
    wr(8'h5e, 8'h03);
    chk("staged fmt", 0, conv_clk_256fs);
    chk("staged cmd", 0, do_compressed);
    apply_cmd(8'h03);
    chk("fmt", 3'b111, {conv_clk_256fs, conv_24bit, do_round16});
    chk("status", 5'b01000, {cs_compressed, cs_copy_ok, cs_preemph, cs_rate_code});
    chk("comp mode", 1, do_compressed);
    $display("test staging done");
    wr(8'h07, 8'h02);
    hdr(3'd2);
    chk("reset pulse", 1, n);
    chk("mute on", 1, soft_mute);
    chk("irq", 1, irq);
    rd(8'h43, rv);
    chk("type field", 8'h02, rv);
    rd(8'h42, rv);
    chk("hdr byte", 8'ha5, rv);
    chk("irq clear", 0, irq);
    hdr(3'd2);
    chk("same type", 0, n);
    wr(8'h4c, 8'h03);
    hdr(3'd1);
    chk("serial no detect", 0, n);
    wr(8'h4c, 8'h05);
    repeat (850) @(negedge clock);
    chk("mute held", 1, soft_mute);
    repeat (200) @(negedge clock);
    chk("mute end", 0, soft_mute);
    $display("test detect done");
    SINK.rx_q.delete();
    stall = 1;
    for (int i = 0; i < 4; i++) push(1, 32'hc0de0000 + i);
    chk("fifo full", 0, comp_ready);
    stall = 0;
    repeat (8) @(negedge clock);
    chk("drained", 4, SINK.rx_q.size());
    foreach (SINK.rx_q[i]) chk("comp word", 32'hc0de0000 + i, SINK.rx_q[i]);
    chk("empty", 0, do_valid);
    $display("test fifo done");
    apply_cmd(8'h02);
    push(0, 32'h1234abcd);
    repeat (4) @(negedge clock);
    chk("lr word", 32'h1234abcd, SINK.rx_q[0]);
    wr(8'h5f, 8'h5a);
    chk("category staged", 0, do_category);
    apply_cmd(8'h82);
    chk("category", 8'h5a, do_category);
    push(0, 32'h1234abcd);
    repeat (4) @(negedge clock);
    chk("aux word", 32'habcd1234, SINK.rx_q[0]);
    $display("test pairs done");
    wr(8'h4d, 8'h00);
    wr(8'h6c, 8'h00);
    crc_error = 1;
    @(negedge clock);
    chk("block mute", 1, block_mute);
    crc_error = 0;
    @(negedge clock);
    chk("block clear", 0, block_mute);
    wr(8'h70, 8'h01);
    pes_input = 1;
    @(negedge clock);
    chk("fds pes", 1, force_downsample_en);
    wr(8'h4c, 8'h03);
    chk("fds es", 0, force_downsample_en);
    wr(8'h4d, 8'h03);
    pcm_16bit_stereo = 0;
    @(negedge clock);
    chk("pcm drop", 1, pcm_drop);
    pcm_16bit_stereo = 1;
    @(negedge clock);
    chk("pcm keep", 0, pcm_drop);
    $display("test misc done");
    ce = 0;
    wr(8'h6f, 8'h03);
    ce = 1;
    rd(8'h6f, rv);
    chk("ce freeze", 0, rv);
    vocal_count = 2'h2;
    @(negedge clock);
    chk("karaoke stereo", 1, karaoke_mode);
    wr(8'h6f, 8'h03);
    chk("karaoke multi", 2, karaoke_mode);
    vocal_count = 2'h0;
    @(negedge clock);
    chk("karaoke off", 0, karaoke_mode);
    $display("test enable and karaoke done");
    reset_n = 0;
    @(negedge clock);
    reset_n = 1;
    chk("mute after reset", 0, soft_mute);
    rd(8'h6f, rv);
    chk("dmx after reset", 0, rv);
    wr(8'h4c, 8'h05);
    apply_cmd(8'h03);
    push(1, 32'h0bad0001);
    hdr(3'd5);
    chk("layer3 no detect", 0, n);
    push(1, 32'h0bad0002);
    repeat (4) @(negedge clock);
    chk("untyped blocked", 0, SINK.rx_q.size());
    hdr(3'd3);
    chk("surround b detect", 1, n);
    push(1, 32'h0bad0003);
    repeat (4) @(negedge clock);
    chk("typed passed", 1, SINK.rx_q.size());
    chk("typed word", 32'h0bad0003, SINK.rx_q[0]);
    $display("test second reset done");
    final_report();
  end
endmodule : aods_top_bench
